// >>> nab_consts.svh
// Timing counts, command codes and address masks for the NAND bus host.
// Assumes a single 250 MHz clock; every count is derived from a time in ns.
// Summary of operation
// - Capture on rise at 30ns, else next fall
// - Host issues 00h after 78h before reading
// - Host drives unused address bits low
// - die_pick_bit low unless two dies share
`ifndef NAB_CONSTS_SVH
`define NAB_CONSTS_SVH

`define NAB_CLK_NS          4
`define NAB_SETUP_NS        12
`define NAB_PULSE_LO_NS     15
`define NAB_PULSE_HI_NS     15
`define NAB_EDO_LIMIT_NS    30

`define NAB_SETUP_CYC       ((`NAB_SETUP_NS + `NAB_CLK_NS - 1) / `NAB_CLK_NS)
`define NAB_LO_CYC          ((`NAB_PULSE_LO_NS + `NAB_CLK_NS - 1) / `NAB_CLK_NS)
`define NAB_HI_CYC          ((`NAB_PULSE_HI_NS + `NAB_CLK_NS - 1) / `NAB_CLK_NS)
`define NAB_READ_PERIOD_NS  ((`NAB_LO_CYC + `NAB_HI_CYC) * `NAB_CLK_NS)
`define NAB_USE_EDO         (`NAB_READ_PERIOD_NS < `NAB_EDO_LIMIT_NS)
`define NAB_CAP_K           ((`NAB_USE_EDO) ? (`NAB_HI_CYC - 1) : 1)
`define NAB_CAP_PAST        (`NAB_CAP_K + 2)

`define NAB_CMD_READ_MODE   8'h00
`define NAB_CMD_STATUS_ENH  8'h78
`define NAB_ADDR2_MASK      8'h1F
`define NAB_ADDR5_MASK_DUAL 8'h0F
`define NAB_ADDR5_MASK_ONE  8'h07
`define NAB_TWO_DIES        1'b0

`define NAB_FIFO_WIDTH      8
`define NAB_FIFO_DEPTH      4

`endif

// >>> nab_pkg.sv
// Types used by the NAND bus host only; its read buffer keeps its own state type.
// Assumes nab_consts.svh supplies all numeric values.
package nab_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SETUP = 3'h1,
      ST_LO    = 3'h2,
      ST_HI    = 3'h3
   } nab_state_t;

   typedef enum logic [1:0] {
      OP_CMD  = 2'h0,
      OP_ADDR = 2'h1,
      OP_WR   = 2'h2,
      OP_RD   = 2'h3
   } nab_op_t;

   typedef struct packed {
      nab_state_t  st;
      nab_op_t     kind;
      logic [7:0]  byte_v;
      logic        tgt;
      logic [3:0]  cnt;
      logic [2:0]  aidx;
      logic        after78;
      logic        pend_rd;
      logic        ready;
      logic [7:0]  s1;
      logic [7:0]  s2;
      logic        b1;
      logic        b2;
      logic        busy;
      logic        sel0_n;
      logic        sel1_n;
      logic        cle;
      logic        ale;
      logic        wrp_n;
      logic        rdp_n;
      logic [7:0]  lanes;
      logic        oe;
      logic        lock_n;
      logic        push;
      logic [7:0]  pdata;
   } nab_host_st_t;

endpackage : nab_pkg

// >>> nab_fifo.sv
// Small valid/ready FIFO that buffers bytes read from the flash.
// Assumes depth is a power of two so the pointers wrap on their own.
module nab_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                full;
      logic                empty;
      logic                avail;
      logic [W-1:0]        head;
   } nab_fifo_st_t;

   nab_fifo_st_t r;
   nab_fifo_st_t n;
   logic         push;
   logic         pop;

   always_comb begin
      n    = r;
      push = in_valid && !r.full;
      pop  = out_ready && !r.empty;
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp        = AW'(r.wp + 1'b1);
      end
      if (pop) begin
         n.rp = AW'(r.rp + 1'b1);
      end
      n.cnt   = (AW+1)'(r.cnt + (AW+1)'(push) - (AW+1)'(pop));
      n.full  = (n.cnt == (AW+1)'(D));
      n.empty = (n.cnt == '0);
      // Head and valid are registered so the outputs come straight from flops
      n.avail = (n.cnt != '0);
      n.head  = n.mem[n.rp];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{default: '0, empty: 1'b1};
      end else begin
         r <= n;
      end
   end

   assign in_ready  = !r.full;
   assign out_valid = r.avail;
   assign out_data  = r.head;

endmodule : nab_fifo

// >>> nab_host.sv
// Host controller for an asynchronous multiplexed NAND flash port.
// Assumes the flash pins are outside this clock domain; lanes and the
// done line are synchronised before use. One user operation, one bus cycle, except a read after 78h, which first issues 00h.
`include "nab_consts.svh"
module nab_host (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       op_valid,
   output logic            op_ready,
   input  wire logic [1:0] op_kind,
   input  wire logic [7:0] op_byte,
   input  wire logic       op_target,
   output logic            rd_valid,
   input  wire logic       rd_ready,
   output logic [7:0]      rd_byte,
   input  wire logic       write_enable,
   output logic            target_busy,
   output logic            target_pick_n,
   output logic            second_target_select_n,
   output logic            cmd_phase_sel,
   output logic            addr_phase_sel,
   output logic            input_pulse_n,
   output logic            output_pulse_n,
   input  wire logic [7:0] io_lanes_in,
   output logic [7:0]      io_lanes_out,
   output logic            io_lanes_oe,
   output logic            program_lock_n,
   input  wire logic       done_line_n
);
   localparam nab_pkg::nab_host_st_t RST_ST = '{
      default: '0,
      st:      nab_pkg::ST_IDLE,
      kind:    nab_pkg::OP_CMD,
      ready:   1'b1,
      b1:      1'b1,
      b2:      1'b1,
      sel0_n:  1'b1,
      sel1_n:  1'b1,
      wrp_n:   1'b1,
      rdp_n:   1'b1
   };

   nab_pkg::nab_host_st_t r;
   nab_pkg::nab_host_st_t n;
   logic                  fifo_in_ready;

   // Clears lanes that lie outside the implemented address space
   function automatic logic [7:0] nab_mask_addr(input logic [2:0] idx, input logic [7:0] b);
      logic [7:0] m;
      m = 8'hFF;
      if (idx == 3'h1) begin
         m = `NAB_ADDR2_MASK;
      end else if (idx == 3'h4) begin
         m = `NAB_TWO_DIES ? `NAB_ADDR5_MASK_DUAL : `NAB_ADDR5_MASK_ONE;
      end
      return b & m;
   endfunction : nab_mask_addr

   always_comb begin
      n      = r;
      n.s1   = io_lanes_in;
      n.s2   = r.s1;
      n.b1   = done_line_n;
      n.b2   = r.b1;
      n.busy = ~r.b2;
      n.push = 1'b0;
      n.lock_n = write_enable;
      case (r.st)
         nab_pkg::ST_IDLE: begin
            if (op_valid && r.ready) begin
               n.ready  = 1'b0;
               n.tgt    = op_target;
               n.kind   = nab_pkg::nab_op_t'(op_kind);
               n.byte_v = op_byte;
               n.cnt    = 4'h0;
               n.st     = nab_pkg::ST_SETUP;
               // A read right after 78h first needs 00h to avoid contention
               if (op_kind == nab_pkg::OP_RD && r.after78) begin
                  n.kind    = nab_pkg::OP_CMD;
                  n.byte_v  = `NAB_CMD_READ_MODE;
                  n.pend_rd = 1'b1;
               end
            end
         end
         nab_pkg::ST_SETUP: begin
            n.sel0_n = r.tgt;
            n.sel1_n = ~r.tgt;
            n.cle    = (r.kind == nab_pkg::OP_CMD);
            n.ale    = (r.kind == nab_pkg::OP_ADDR);
            n.oe     = (r.kind != nab_pkg::OP_RD);
            n.lanes  = (r.kind == nab_pkg::OP_ADDR) ? nab_mask_addr(r.aidx, r.byte_v) : r.byte_v;
            if (r.cnt == 4'(`NAB_SETUP_CYC - 1)) begin
               // A read waits for buffer room so a captured byte is never lost
               if (r.kind != nab_pkg::OP_RD || fifo_in_ready) begin
                  n.cnt = 4'h0;
                  n.st  = nab_pkg::ST_LO;
                  if (r.kind == nab_pkg::OP_RD) begin
                     n.rdp_n = 1'b0;
                  end else begin
                     n.wrp_n = 1'b0;
                  end
               end
            end else begin
               n.cnt = 4'(r.cnt + 1'b1);
            end
         end
         nab_pkg::ST_LO: begin
            n.cnt = 4'(r.cnt + 1'b1);
            if (r.cnt == 4'(`NAB_LO_CYC - 1)) begin
               n.cnt   = 4'h0;
               n.st    = nab_pkg::ST_HI;
               n.wrp_n = 1'b1;
               n.rdp_n = 1'b1;
               if (r.kind == nab_pkg::OP_CMD) begin
                  n.aidx = 3'h0;
                  if (r.byte_v == `NAB_CMD_STATUS_ENH) begin
                     n.after78 = 1'b1;
                  end else if (r.byte_v == `NAB_CMD_READ_MODE) begin
                     n.after78 = 1'b0;
                  end
               end else if (r.kind == nab_pkg::OP_ADDR && r.aidx != 3'h7) begin
                  n.aidx = 3'(r.aidx + 1'b1);
               end
            end
         end
         nab_pkg::ST_HI: begin
            n.cnt = 4'(r.cnt + 1'b1);
            // Capture point moves to the next fall when the cycle is short
            if (r.kind == nab_pkg::OP_RD && r.cnt == 4'(`NAB_CAP_K)) begin
               n.push  = 1'b1;
               n.pdata = r.s2;
            end
            if (r.cnt == 4'(`NAB_HI_CYC - 1)) begin
               n.cnt = 4'h0;
               if (r.pend_rd) begin
                  n.pend_rd = 1'b0;
                  n.kind    = nab_pkg::OP_RD;
                  n.st      = nab_pkg::ST_SETUP;
               end else begin
                  n.st     = nab_pkg::ST_IDLE;
                  n.ready  = 1'b1;
                  n.sel0_n = 1'b1;
                  n.sel1_n = 1'b1;
                  n.cle    = 1'b0;
                  n.ale    = 1'b0;
                  n.oe     = 1'b0;
               end
            end
         end
         default: begin
            n = RST_ST;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= RST_ST;
      end else begin
         r <= n;
      end
   end

   nab_fifo #(
      .W(`NAB_FIFO_WIDTH),
      .D(`NAB_FIFO_DEPTH)
   ) u_rd_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (r.push),
      .in_ready  (fifo_in_ready),
      .in_data   (r.pdata),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_byte)
   );

   assign op_ready               = r.ready;
   assign target_busy            = r.busy;
   assign target_pick_n          = r.sel0_n;
   assign second_target_select_n = r.sel1_n;
   assign cmd_phase_sel          = r.cle;
   assign addr_phase_sel         = r.ale;
   assign input_pulse_n          = r.wrp_n;
   assign output_pulse_n         = r.rdp_n;
   assign io_lanes_out           = r.lanes;
   assign io_lanes_oe            = r.oe;
   assign program_lock_n         = r.lock_n;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_capture_edge_point: assert property (
      r.push |-> r.rdp_n && !$past(r.rdp_n, `NAB_CAP_PAST))
      else $error("read byte captured at the wrong strobe phase");
   chk_read_mode_first: assert property (
      $fell(r.rdp_n) |-> !r.after78)
      else $error("data read while status-enhanced mode still set");
   chk_addr2_upper_low: assert property (
      (r.st == nab_pkg::ST_LO && r.ale && r.aidx == 3'h1) |-> r.lanes[7:5] == 3'h0)
      else $error("second address cycle upper lanes not low");
   chk_addr5_upper_low: assert property (
      (r.st == nab_pkg::ST_LO && r.ale && r.aidx == 3'h4) |-> r.lanes[7:4] == 4'h0)
      else $error("fifth address cycle upper lanes not low");
   chk_die_bit_low: assert property (
      (!`NAB_TWO_DIES && !r.wrp_n && r.ale && r.aidx == 3'h4) |-> !r.lanes[3])
      else $error("die pick bit driven high on a single die target");
   chk_write_pulse_width: assert property (
      $fell(r.wrp_n) |-> !r.wrp_n [*4] ##1 r.wrp_n)
      else $error("input pulse low phase has the wrong length");
   chk_one_target_pick: assert property (
      (!r.wrp_n || !r.rdp_n) |-> (r.sel0_n != r.sel1_n) && (r.sel0_n == r.tgt))
      else $error("pulse issued without exactly one target picked");
   chk_idle_bus_quiet: assert property (
      (r.st == nab_pkg::ST_IDLE) |-> r.wrp_n && r.rdp_n && !r.oe && r.sel0_n && r.sel1_n)
      else $error("bus not quiet while idle");
   chk_drive_direction: assert property (
      (!r.wrp_n |-> r.oe) and (!r.rdp_n |-> !r.oe))
      else $error("lane drive direction wrong during a pulse");
   chk_pulses_exclusive: assert property (
      !(!r.wrp_n && !r.rdp_n))
      else $error("both pulses low together");

   cov_command_cycle: cover property ($rose(r.wrp_n) && r.cle);
   cov_address_cycle: cover property ($rose(r.wrp_n) && r.ale);
   cov_read_capture: cover property (r.push);
   cov_auto_read_mode: cover property ($rose(r.pend_rd));

endmodule : nab_host

// >>> nab_flash_model.sv
// Behavioural flash target: command, address, cache and status on strobe edges.
// Assumes the bench resolves the shared lanes and drives busy and done itself.
module nab_flash_model (
   input  wire logic       sel_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic       busy,
   input  wire logic [7:0] lanes,
   output logic [7:0]      q,
   output logic            q_en
);
   timeunit 1ns;
   timeprecision 1ps;
   // No lane strobe pin at all: it floats and is never used
   logic [7:0] cmd_r;
   logic [7:0] addr_r;
   logic [7:0] last_wr;
   logic [7:0] cache [8];
   logic [2:0] ptr;
   logic [2:0] aidx;
   logic       stat_mode;
   logic       after78;
   logic       col_bad;
   logic       standby;
   // Deselected and idle means low-power standby; a busy die delays it
   assign standby = sel_n && !busy;
   initial begin
      cmd_r = 8'h00;
      addr_r = 8'h00;
      last_wr = 8'h00;
      ptr = 3'h0;
      aidx = 3'h0;
      stat_mode = 1'b0;
      after78 = 1'b0;
      col_bad = 1'b0;
      q = 8'hA5;
      q_en = 1'b0;
      for (int i = 0; i < 8; i++) cache[i] = 8'h10 + 8'(i);
   end
   // Only strobe edges and the deselect edge act; with both strobes high nothing is latched
   always @(posedge wr_n) begin
      if (!sel_n && rd_n) begin
         if (cle && !ale) begin
            if (!busy || lanes == 8'h70 || lanes == 8'h78) begin
               cmd_r = lanes;
               aidx = 3'h0;
               stat_mode = (lanes == 8'h70 || lanes == 8'h78);
               after78 = (lanes == 8'h78);
            end
         end else if (ale && !cle) begin
            if (!busy || after78) begin
               // Columns from 10E0h upward do not exist in the page
               if (aidx == 3'h1 && !after78) begin
                  col_bad = ({lanes[4:0], addr_r} >= 13'h10E0);
               end
               addr_r = lanes;
               // Strobe interface keeps column bit 0 as sent; nothing is forced
               if (aidx == 3'h0 && !after78) ptr = lanes[2:0];
               aidx = aidx + 3'h1;
            end
         end else if (!cle && !ale && !busy) begin
            cache[ptr] = lanes;
            last_wr = lanes;
            ptr = ptr + 3'h1;
         end
      end
   end
   always @(negedge rd_n) begin
      if (!sel_n && wr_n && !cle && !ale) begin
         if (stat_mode) begin
            q = {1'b1, ~busy, 6'h00};
            q_en = 1'b1;
         end else if (!busy) begin
            q = cache[ptr];
            q_en = 1'b1;
            ptr = ptr + 3'h1;
         end
      end
   end
   // Each release edge inverts the lanes: the strobe rise shows the inverse of the last byte, a later deselect the byte again
   always @(posedge rd_n or posedge sel_n) begin
      q = ~q;
      q_en = 1'b0;
   end
endmodule : nab_flash_model

// >>> nab_host_bench.sv
// Self-checking bench for the NAND bus host with two modelled targets.
// Assumes the host's CONTRACT timing; inputs change on the falling edge.
module nab_host_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [1:0] k; logic [7:0] b; logic [7:0] e;} nab_row_t;
   localparam nab_row_t ROWS [12] = '{
      '{2'h0, 8'h80, 8'h80}, '{2'h1, 8'h02, 8'h02}, '{2'h1, 8'hFF, 8'h1F},
      '{2'h1, 8'hAA, 8'hAA}, '{2'h1, 8'h55, 8'h55}, '{2'h1, 8'hFF, 8'h07},
      '{2'h2, 8'h3C, 8'h3C}, '{2'h2, 8'hC3, 8'hC3}, '{2'h0, 8'h00, 8'h00},
      '{2'h1, 8'h02, 8'h02}, '{2'h3, 8'h00, 8'h3C}, '{2'h3, 8'h00, 8'hC3}};
   logic       clk, rst, op_valid, op_ready, op_target, rd_valid, rd_ready, write_enable;
   logic [1:0] op_kind;
   logic [7:0] op_byte, rd_byte, io_lanes_in, io_lanes_out, q0, q1;
   logic       target_busy, target_pick_n, second_target_select_n, cmd_phase_sel;
   logic       addr_phase_sel, input_pulse_n, output_pulse_n, io_lanes_oe;
   logic       program_lock_n, done_line_n, busy0, q0_en, q1_en;
   int         failures, tests_run;
   assign io_lanes_in = io_lanes_oe ? io_lanes_out : q0_en ? q0 : q1_en ? q1 : q0;
   assign done_line_n = ~busy0;
   nab_host i_dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
      .op_kind(op_kind), .op_byte(op_byte), .op_target(op_target), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_byte(rd_byte), .write_enable(write_enable),
      .target_busy(target_busy), .target_pick_n(target_pick_n),
      .second_target_select_n(second_target_select_n), .cmd_phase_sel(cmd_phase_sel),
      .addr_phase_sel(addr_phase_sel), .input_pulse_n(input_pulse_n),
      .output_pulse_n(output_pulse_n), .io_lanes_in(io_lanes_in),
      .io_lanes_out(io_lanes_out), .io_lanes_oe(io_lanes_oe),
      .program_lock_n(program_lock_n), .done_line_n(done_line_n));
   nab_flash_model i_flash0 (.sel_n(target_pick_n), .cle(cmd_phase_sel),
      .ale(addr_phase_sel), .wr_n(input_pulse_n), .rd_n(output_pulse_n), .busy(busy0),
      .lanes(io_lanes_in), .q(q0), .q_en(q0_en));
   nab_flash_model i_flash1 (.sel_n(second_target_select_n), .cle(cmd_phase_sel),
      .ale(addr_phase_sel), .wr_n(input_pulse_n), .rd_n(output_pulse_n), .busy(1'b0),
      .lanes(io_lanes_in), .q(q1), .q_en(q1_en));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic do_op(input logic [1:0] k, input logic [7:0] b, input logic t,
                        input bit wait_done);
      int n;
      n = 0;
      @(negedge clk);
      op_valid = 1'b1;
      op_kind = k;
      op_byte = b;
      op_target = t;
      // Ready is read at the falling edge, so the taking edge is known without a race
      while (op_ready !== 1'b1 && n < 200) begin
         n++;
         @(negedge clk);
      end
      @(negedge clk);
      op_valid = 1'b0;
      while (wait_done && op_ready !== 1'b1 && n < 200) begin
         n++;
         @(negedge clk);
      end
      if (n >= 200) check(8'h00, 8'h01, "operation hung");
   endtask : do_op
   // Consumer stalls until called; one byte popped per call
   task automatic pop(input logic [7:0] e);
      int n;
      n = 0;
      while (rd_valid !== 1'b1 && n < 100) begin
         n++;
         @(negedge clk);
      end
      check(rd_byte, e, "read byte");
      rd_ready = 1'b1;
      @(negedge clk);
      rd_ready = 1'b0;
   endtask : pop
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      stop_test();
   end
   initial begin
      failures = 0;
      tests_run = 0;
      rst = 1'b1;
      {op_valid, op_target, rd_ready, write_enable, busy0} = 5'h00;
      op_kind = 2'h0;
      op_byte = 8'h00;
      repeat (16) @(negedge clk);
      check({op_ready, target_pick_n, second_target_select_n, input_pulse_n,
             output_pulse_n, io_lanes_oe, program_lock_n, rd_valid}, 8'hF8, "reset");
      rst = 1'b0;
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         do_op(ROWS[i].k, ROWS[i].b, 1'b0, 1'b1);
         case (ROWS[i].k)
            2'h0: check(i_flash0.cmd_r, ROWS[i].e, "command");
            2'h1: check(i_flash0.addr_r, ROWS[i].e, "address");
            2'h2: check(i_flash0.last_wr, ROWS[i].e, "data in");
            default: pop(ROWS[i].e);
         endcase
      end
      check({7'h00, i_flash0.col_bad}, 8'h01, "column range");
      $display("test rows done");
      do_op(2'h0, 8'h90, 1'b1, 1'b1);
      check(i_flash1.cmd_r, 8'h90, "second target");
      check(i_flash0.cmd_r, 8'h00, "first target");
      check({7'h00, i_flash0.standby}, 8'h01, "idle standby");
      $display("test targets done");
      busy0 = 1'b1;
      repeat (6) @(negedge clk);
      check({7'h00, target_busy}, 8'h01, "busy seen");
      check({7'h00, i_flash0.standby}, 8'h00, "busy standby");
      do_op(2'h0, 8'h80, 1'b0, 1'b1);
      check(i_flash0.cmd_r, 8'h00, "busy command");
      do_op(2'h2, 8'h99, 1'b0, 1'b1);
      check(i_flash0.last_wr, 8'hC3, "busy data in");
      do_op(2'h0, 8'h70, 1'b0, 1'b1);
      check(i_flash0.cmd_r, 8'h70, "status command");
      do_op(2'h3, 8'h00, 1'b0, 1'b1);
      pop(8'h80);
      do_op(2'h0, 8'h78, 1'b0, 1'b1);
      do_op(2'h1, 8'h01, 1'b0, 1'b1);
      check(i_flash0.addr_r, 8'h01, "busy address");
      busy0 = 1'b0;
      repeat (6) @(negedge clk);
      do_op(2'h3, 8'h00, 1'b0, 1'b1);
      check(i_flash0.cmd_r, 8'h00, "read mode inserted");
      pop(8'h14);
      $display("test busy done");
      write_enable = 1'b1;
      repeat (3) @(negedge clk);
      check({7'h00, program_lock_n}, 8'h01, "lock pin");
      $display("test lock done");
      for (int j = 0; j < 5; j++) do_op(2'h3, 8'h00, 1'b0, j < 4);
      repeat (40) @(negedge clk);
      check({6'h00, op_ready, rd_valid}, 8'h01, "full buffer stalls");
      pop(8'h15);
      pop(8'h16);
      pop(8'h17);
      pop(8'h10);
      pop(8'h11);
      $display("test buffer done");
      do_op(2'h0, 8'h80, 1'b0, 1'b0);
      repeat (3) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check({op_ready, target_pick_n, second_target_select_n, input_pulse_n,
             output_pulse_n, io_lanes_oe, program_lock_n, rd_valid}, 8'hF8, "mid reset");
      rst = 1'b0;
      do_op(2'h0, 8'h70, 1'b0, 1'b1);
      check(i_flash0.cmd_r, 8'h70, "after reset");
      $display("test mid reset done");
      stop_test();
   end
endmodule : nab_host_bench
